// *** sim/cfg_link_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module cfg_link_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mode_pin_0,
  input wire logic mode_pin_1,
  input wire logic mode_pin_2,
  input wire logic mode_pullup_en,
  input wire logic config_clock,
  input wire logic dev_config_clock_oe_n,
  input wire logic host_config_clock_oe_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe,
  input wire logic chip_select_low,
  input wire logic chip_select_high,
  input wire logic rdy_busy,
  input wire logic chain_out,
  input wire logic init_line
);
  logic config_clock_prev_reg;
  logic write_on_prev_reg;
  logic [3:0] busy_rises_reg;
  logic [3:0] since_write_reg;
  logic [7:0] ready_cnt_reg;
  wire logic [2:0] pins = {mode_pin_2, mode_pin_1, mode_pin_0};
  wire logic config_clock_rise = config_clock && !config_clock_prev_reg;
  wire logic write_on = !chip_select_low && chip_select_high &&
                        read_strobe && !write_strobe_n;
  wire logic write_end = write_strobe_n && write_on_prev_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clk)
  begin
    config_clock_prev_reg <= config_clock;
    write_on_prev_reg <= write_on;
  end

  // busy length is judged in config clock rises, the unit of the limit
  always_ff @(posedge clk)
  begin
    if (!rst_n || rdy_busy)
      busy_rises_reg <= 4'h0;
    else if (config_clock_rise && busy_rises_reg != 4'hf)
      busy_rises_reg <= busy_rises_reg + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || !rdy_busy)
      ready_cnt_reg <= 8'h00;
    else if (ready_cnt_reg != 8'hff)
      ready_cnt_reg <= ready_cnt_reg + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      since_write_reg <= 4'hf;
    else if (write_end)
      since_write_reg <= 4'h0;
    else if (since_write_reg != 4'hf)
      since_write_reg <= since_write_reg + 4'h1;
  end

  a_init_held_low: assert property ($rose(rst_n) |-> !init_line [*8])
    else $error("init line released too early");
  a_pullups_in_init: assert property (!init_line |-> mode_pullup_en)
    else $error("mode pull-ups off during init");
  a_slave_no_clock: assert property (
    init_line && $past(init_line) && pins == 3'h7 |-> dev_config_clock_oe_n)
    else $error("device drives clock in serial slave mode");
  a_async_drives_clock: assert property (
    init_line && $past(init_line, 3) && pins == 3'h5 |-> !dev_config_clock_oe_n)
    else $error("device not driving clock in async mode");
  a_chain_on_low: assert property (
    $changed(chain_out) |-> !config_clock)
    else $error("chain output changed while clock high");
  a_source_waits_init: assert property (
    ($rose(config_clock) && !host_config_clock_oe_n) || $fell(write_strobe_n)
    |-> init_line)
    else $error("source started before init line high");
  a_busy_after_write: assert property (
    $fell(rdy_busy) |-> since_write_reg <= 4'h8)
    else $error("busy without a qualified write");
  a_busy_length: assert property ($rose(rdy_busy) |->
    busy_rises_reg >= 4'h2 && busy_rises_reg <= 4'h9)
    else $error("busy length out of range");
  a_write_end_ready: assert property (
    $rose(write_strobe_n) |-> ready_cnt_reg >= 8'd14)
    else $error("write ended before ready held one period");
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, want) \
  begin \
    num_checks++; \
    if ((got) !== (want)) \
    begin \
      fail_count++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want); \
    end \
  end
module tb;
  import cfg_pkg::*;
  logic clk;
  logic rst_n;
  logic [2:0] mode_sel;
  logic mode_drive;
  logic [7:0] tx_byte;
  logic tx_valid;
  logic tx_ready;
  logic link_idle;
  logic cfg_bit;
  logic cfg_bit_valid;
  logic cfg_done;
  mode_t cfg_mode;
  int fail_count;
  int num_checks;
  logic bits_q[$];
  logic chain_q[$];
  logic [7:0] sent_q[$];
  logic config_clock_prev;

  cfg_link_if link ();
  cfg_device cfg_device_inst (.clk(clk), .rst_n(rst_n), .link(link),
    .cfg_bit(cfg_bit), .cfg_bit_valid(cfg_bit_valid), .cfg_done(cfg_done),
    .cfg_mode(cfg_mode));
  cfg_host cfg_host_inst (.clk(clk), .rst_n(rst_n), .link(link),
    .mode_sel(mode_sel), .mode_drive(mode_drive), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .link_idle(link_idle));
  cfg_link_asserts cfg_link_asserts_inst (.clk(clk), .rst_n(rst_n),
    .mode_pin_0(link.mode_pin_0), .mode_pin_1(link.mode_pin_1),
    .mode_pin_2(link.mode_pin_2), .mode_pullup_en(link.mode_pullup_en),
    .config_clock(link.config_clock), .dev_config_clock_oe_n(link.dev_config_clock_oe_n),
    .host_config_clock_oe_n(link.host_config_clock_oe_n),
    .write_strobe_n(link.write_strobe_n), .read_strobe(link.read_strobe),
    .chip_select_low(link.chip_select_low),
    .chip_select_high(link.chip_select_high), .rdy_busy(link.rdy_busy),
    .chain_out(link.chain_out), .init_line(link.init_line));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // chain output is sampled at each link clock rise, as a next device would
  always @(posedge clk)
  begin
    config_clock_prev <= link.config_clock;
    if (cfg_bit_valid === 1'b1)
      bits_q.push_back(cfg_bit);
    if (link.config_clock === 1'b1 && config_clock_prev === 1'b0)
      chain_q.push_back(link.chain_out);
  end

  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic timeout_fail();
    fail_count++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  endtask

  task automatic do_reset(input logic [2:0] pat, input logic drv);
    int n = 0;
    rst_n <= 1'b0;
    mode_sel <= pat;
    mode_drive <= drv;
    tx_valid <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bits_q.delete();
    chain_q.delete();
    sent_q.delete();
    while (link.init_line !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 100)
        timeout_fail();
    end
  endtask

  // tx_valid stays up between bytes; the caller lowers it after the last
  task automatic send_byte(input logic [7:0] b);
    int n = 0;
    tx_byte <= b;
    tx_valid <= 1'b1;
    sent_q.push_back(b);
    do
    begin
      @(posedge clk);
      n++;
      if (n > 400)
        timeout_fail();
    end
    while (tx_ready !== 1'b1);
  endtask

  task automatic wait_count(input int want, input bit chain);
    int n = 0;
    while ((chain ? chain_q.size() : bits_q.size()) < want)
    begin
      @(posedge clk);
      n++;
      if (n > 2000)
        timeout_fail();
    end
    repeat (30) @(posedge clk);
  endtask

  task automatic t_modes();
    logic [2:0] pats [6] = '{3'h7, 3'h0, 3'h3, 3'h5, 3'h6, 3'h4};
    mode_t exps [6] = '{MODE_SLAVE_SER, MODE_MASTER_SER, MODE_SYNC_PER,
                        MODE_ASYNC_PER, MODE_PAR_DOWN, MODE_PAR_UP};
    int n;
    do_reset(3'h0, 1'b0);
    `CHK(cfg_mode, MODE_SLAVE_SER)
    for (int i = 0; i < 6; i++)
    begin
      do_reset(pats[i], 1'b1);
      `CHK(cfg_mode, exps[i])
      if (pats[i] == 3'h6 || pats[i] == 3'h4)
      begin
        n = 0;
        while (link.read_clock !== 1'b1 && n < 200)
        begin
          @(posedge clk);
          n++;
        end
        `CHK(link.read_clock, 1'b1)
        `CHK(link.prom_address, (pats[i] == 3'h6) ? 18'h3ffff : 18'h0)
      end
      repeat (3) @(posedge clk);
      `CHK(link.dev_config_clock_oe_n, pats[i] == 3'h7 || pats[i] == 3'h3)
    end
  endtask

  task automatic t_serial();
    logic want;
    do_reset(3'h7, 1'b1);
    for (int i = 0; i < 9; i++)
      send_byte(8'h5a ^ 8'(i * 37));
    tx_valid <= 1'b0;
    wait_count(72, 1'b1);
    `CHK(bits_q.size(), 64)
    `CHK(cfg_done, 1'b1)
    for (int i = 0; i < 64; i++)
      `CHK(bits_q[i], sent_q[i / 8][7 - i % 8])
    // rise k carries the bit taken at rise k-1
    for (int i = 1; i < 72; i++)
    begin
      want = (i < 9 || i > 64) ? sent_q[(i - 1) / 8][7 - (i - 1) % 8] : 1'b1;
      `CHK(chain_q[i], want)
    end
  endtask

  task automatic t_async();
    do_reset(3'h5, 1'b1);
    for (int i = 0; i < 4; i++)
      send_byte(8'hc3 + 8'(i * 29));
    tx_valid <= 1'b0;
    wait_count(32, 1'b0);
    `CHK(bits_q.size(), 32)
    for (int i = 0; i < 32; i++)
      `CHK(bits_q[i], sent_q[i / 8][7 - i % 8])
    `CHK(link.read_strobe, 1'b1)
    `CHK(link_idle, 1'b1)
  endtask

  initial
  begin
    rst_n = 1'b0;
    mode_sel = 3'h7;
    mode_drive = 1'b0;
    tx_byte = 8'h00;
    tx_valid = 1'b0;
    config_clock_prev = 1'b0;
    fail_count = 0;
    num_checks = 0;
    @(posedge clk);
    t_modes();
    t_serial();
    t_async();
    stop_test();
  end
endmodule
`default_nettype wire

// *** src/cfg_consts.svh ***
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH

// mode pin patterns, order m2 m1 m0
`define CFG_MODE_SLAVE_SER 3'h7
`define CFG_MODE_MASTER_SER 3'h0
`define CFG_MODE_SYNC_PER 3'h3
`define CFG_MODE_ASYNC_PER 3'h5
`define CFG_MODE_PAR_DOWN 3'h6
`define CFG_MODE_PAR_UP 3'h4

`define CFG_CLK_HZ 125000000
// fastest config clock the link allows
`define CFG_CONFIG_CLOCK_MAX_HZ 10000000
// system cycles per config clock half period, rounded up
`define CFG_CONFIG_CLOCK_HALF \
  ((`CFG_CLK_HZ + 2 * `CFG_CONFIG_CLOCK_MAX_HZ - 1) / (2 * `CFG_CONFIG_CLOCK_MAX_HZ))
`define CFG_HALF_W 4
`define CFG_BUSY_MIN_CONFIG_CLOCK 4'h2
`define CFG_BUSY_MAX_CONFIG_CLOCK 4'h9
`define CFG_INIT_CYCLES 8'h10
`define CFG_PREAMBLE_BITS 16'h0008
`define CFG_OWN_BITS 16'h0040
`define CFG_ADDR_W 18
`define CFG_ADDR_UP_START 18'h00000
`define CFG_ADDR_DOWN_START 18'h3ffff
`define CFG_BYTE_BITS 4'h8

`endif

// *** src/cfg_device.sv ***
// Contract
// - mode pins 111 select serial slave load
// - weak pull-ups on mode pins while configuring
// - decode 000, 011, 101, 110, 100 to other modes
// - parallel master drives address, read clock, byte
// - host clocks serial bits, device samples rising
// - lead device repeats preamble and overflow bits
// - chain output changes on falling clock edge
// - source waits for shared init line high
// - init status driven open-drain while configuring
// - write active: both selects, strobe low, read high
// - byte captured at write strobe rising edge
// - busy lasts 2 to 9 config clocks
// - busy while converter cannot take a byte
// - shortest busy empty, longest before shifting
// - host may start write once busy
// - host ends write after one ready clock
// - serialise new byte after previous, clock aligned
`timescale 1ns/1ns
`default_nettype none
`include "cfg_consts.svh"
module cfg_device (
  input wire logic clk,
  input wire logic rst_n,
  cfg_link_if.dev link,
  output logic cfg_bit,
  output logic cfg_bit_valid,
  output logic cfg_done,
  output cfg_pkg::mode_t cfg_mode
);
  import cfg_pkg::*;

  logic [16:0] pins_q;
  logic [16:0] pins_p;
  pin_sync #(.W(17)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({link.mode_pin_2, link.mode_pin_1, link.mode_pin_0,
        link.config_clock, link.din, link.write_strobe_n,
        link.read_strobe, link.chip_select_low, link.chip_select_high,
        link.data}),
    .q(pins_q),
    .q_prev(pins_p)
  );

  wire [2:0] mode_s = pins_q[16:14];
  wire config_clock_s = pins_q[13];
  wire config_clock_p = pins_p[13];
  wire din_s = pins_q[12];
  wire ws_n_s = pins_q[11];
  wire ws_n_p = pins_p[11];
  wire rs_s = pins_q[10];
  wire csl_s = pins_q[9];
  wire csh_s = pins_q[8];
  wire [7:0] data_s = pins_q[7:0];
  wire [7:0] data_p = pins_p[7:0];

  dev_state_t state_reg, state_next;
  mode_t mode_reg;
  logic [7:0] init_cnt_reg;
  logic [`CFG_HALF_W-1:0] div_reg;
  logic config_clock_reg;
  logic wr_act_reg;
  logic in_full_reg;
  logic [7:0] in_byte_reg;
  logic [7:0] sh_byte_reg;
  logic [3:0] sh_cnt_reg;
  logic [3:0] min_cnt_reg;
  logic [15:0] bit_cnt_reg;
  logic chain_pend_reg;
  logic chain_out_reg;
  logic rdy_reg;
  logic rclk_reg;
  logic [`CFG_ADDR_W-1:0] addr_reg;
  logic init_oe_n_reg;
  logic config_clock_oe_n_reg;
  logic pullup_reg;
  logic hdc_reg;
  logic bit_reg;
  logic bit_valid_reg;

  // master and async modes own the clock
  wire serial_mode = (mode_reg == MODE_SLAVE_SER) ||
                     (mode_reg == MODE_MASTER_SER);
  wire par_mode = (mode_reg == MODE_PAR_DOWN) || (mode_reg == MODE_PAR_UP);
  wire per_mode = (mode_reg == MODE_ASYNC_PER) || (mode_reg == MODE_SYNC_PER);
  wire drives_clk = !(mode_reg == MODE_SLAVE_SER) &&
                    !(mode_reg == MODE_SYNC_PER);
  wire running = (state_reg != ST_INIT);
  wire div_wrap = (div_reg == `CFG_HALF_W'(`CFG_CONFIG_CLOCK_HALF - 1));
  wire int_rise = running && div_wrap && !config_clock_reg;
  wire int_fall = running && div_wrap && config_clock_reg;
  // external clock edges seen after the synchroniser
  wire ext_rise = running && config_clock_s && !config_clock_p;
  wire ext_fall = running && !config_clock_s && config_clock_p;
  wire rise = drives_clk ? int_rise : ext_rise;
  wire fall = drives_clk ? int_fall : ext_fall;

  // write qualified by all four controls
  wire wr_act = !csl_s && !ws_n_s && rs_s && csh_s;
  // capture on the strobe's rising edge, data from before it
  wire wr_capture = (mode_reg == MODE_ASYNC_PER) && wr_act_reg &&
                    ws_n_s && !ws_n_p;
  wire sp_load = (mode_reg == MODE_SYNC_PER) && ext_rise;
  wire par_load = par_mode && int_rise && rclk_reg;
  wire in_load = !in_full_reg && (wr_capture || sp_load || par_load);
  wire [7:0] in_src = wr_capture ? data_p : data_s;
  // next byte moves only when the shifter is empty, on a clock edge
  wire xfer = !serial_mode && in_full_reg && (sh_cnt_reg == 4'h0) && rise;
  wire sh_step = !serial_mode && (sh_cnt_reg != 4'h0) && rise;

  wire bit_take = running && (serial_mode ? rise : sh_step);
  wire bit_val = serial_mode ? din_s : sh_byte_reg[7];
  wire in_pre = (bit_cnt_reg < `CFG_PREAMBLE_BITS);
  wire in_own = (bit_cnt_reg < `CFG_OWN_BITS);
  wire to_core = bit_take && in_own;
  wire to_chain = bit_take && (in_pre || !in_own);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT:
        if (init_cnt_reg == `CFG_INIT_CYCLES)
          state_next = ST_LOAD;
      ST_LOAD:
        if (!in_own)
          state_next = ST_DONE;
      ST_DONE:
        state_next = ST_DONE;
      default:
        state_next = ST_INIT;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_INIT;
      mode_reg <= MODE_SLAVE_SER;
      init_cnt_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_INIT)
        init_cnt_reg <= init_cnt_reg + 8'h01;
      // mode strap taken as init ends
      if (state_reg == ST_INIT && state_next == ST_LOAD)
        mode_reg <= mode_decode(mode_s);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_reg <= '0;
      config_clock_reg <= 1'b0;
    end
    else if (running)
    begin
      div_reg <= div_wrap ? '0 : div_reg + `CFG_HALF_W'(1);
      if (div_wrap)
        config_clock_reg <= !config_clock_reg;
    end
  end

  // two-stage converter: input register then shifter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_act_reg <= 1'b0;
      in_full_reg <= 1'b0;
      in_byte_reg <= 8'h00;
      sh_byte_reg <= 8'h00;
      sh_cnt_reg <= 4'h0;
      min_cnt_reg <= 4'h0;
    end
    else
    begin
      wr_act_reg <= wr_act;
      if (in_load)
      begin
        in_full_reg <= 1'b1;
        in_byte_reg <= in_src;
      end
      else if (xfer)
        in_full_reg <= 1'b0;
      if (xfer)
      begin
        sh_byte_reg <= in_byte_reg;
        sh_cnt_reg <= `CFG_BYTE_BITS;
      end
      else if (sh_step)
      begin
        sh_byte_reg <= {sh_byte_reg[6:0], 1'b0};
        sh_cnt_reg <= sh_cnt_reg - 4'h1;
      end
      // floor on busy; the ceiling of 9 follows from 8 shifts + 1
      if (in_load)
        min_cnt_reg <= `CFG_BUSY_MIN_CONFIG_CLOCK;
      else if (rise && min_cnt_reg != 4'h0)
        min_cnt_reg <= min_cnt_reg - 4'h1;
    end
  end

  // parallel master: read clock high for a half period, byte at its end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rclk_reg <= 1'b0;
      addr_reg <= `CFG_ADDR_UP_START;
    end
    else
    begin
      if (state_reg == ST_INIT)
        addr_reg <= (mode_decode(mode_s) == MODE_PAR_DOWN) ?
                    `CFG_ADDR_DOWN_START : `CFG_ADDR_UP_START;
      else if (par_load)
        addr_reg <= (mode_reg == MODE_PAR_DOWN) ? addr_reg - 1'b1 :
                    addr_reg + 1'b1;
      if (par_mode && int_fall && !in_full_reg && state_reg == ST_LOAD)
        rclk_reg <= 1'b1;
      else if (int_rise)
        rclk_reg <= 1'b0;
    end
  end

  // bits past the preamble stay home until the own length is used up
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bit_cnt_reg <= 16'h0000;
      chain_pend_reg <= 1'b1;
      chain_out_reg <= 1'b1;
      bit_reg <= 1'b0;
      bit_valid_reg <= 1'b0;
    end
    else
    begin
      if (bit_take && in_own)
        bit_cnt_reg <= bit_cnt_reg + 16'h0001;
      if (bit_take)
        chain_pend_reg <= to_chain ? bit_val : 1'b1;
      if (fall)
        chain_out_reg <= chain_pend_reg;
      bit_valid_reg <= to_core;
      if (to_core)
        bit_reg <= bit_val;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdy_reg <= 1'b1;
      init_oe_n_reg <= 1'b0;
      config_clock_oe_n_reg <= 1'b1;
      pullup_reg <= 1'b1;
      hdc_reg <= 1'b1;
    end
    else
    begin
      // only the peripheral modes have a handshake pin to show busy on
      rdy_reg <= !(per_mode &&
                   (in_full_reg || in_load || min_cnt_reg != 4'h0));
      init_oe_n_reg <= (state_next != ST_INIT);
      config_clock_oe_n_reg <= !(running && drives_clk);
      pullup_reg <= (state_reg != ST_DONE);
      hdc_reg <= (state_next != ST_DONE);
    end
  end

  assign link.init_out = 1'b0;
  assign link.init_oe_n = init_oe_n_reg;
  assign link.dev_config_clock = config_clock_reg;
  assign link.dev_config_clock_oe_n = config_clock_oe_n_reg;
  assign link.rdy_busy = rdy_reg;
  assign link.chain_out = chain_out_reg;
  assign link.mode_pullup_en = pullup_reg;
  assign link.high_during_cfg = hdc_reg;
  assign link.low_during_cfg = !hdc_reg;
  assign link.prom_address = addr_reg;
  assign link.read_clock = rclk_reg;
  assign cfg_bit = bit_reg;
  assign cfg_bit_valid = bit_valid_reg;
  assign cfg_done = !hdc_reg;
  assign cfg_mode = mode_reg;
endmodule
`default_nettype wire

// *** src/cfg_host.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cfg_consts.svh"
module cfg_host (
  input wire logic clk,
  input wire logic rst_n,
  cfg_link_if.host link,
  input wire logic [2:0] mode_sel,
  input wire logic mode_drive,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic link_idle
);
  import cfg_pkg::*;

  logic [1:0] st_q;
  logic [1:0] st_p;
  pin_sync #(.W(2)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({link.init_line, link.rdy_busy}),
    .q(st_q),
    .q_prev(st_p)
  );
  wire init_s = st_q[1];
  wire rdy_s = st_q[0];
  wire rdy_fell = !st_q[0] && st_p[0];

  host_state_t state_reg;
  logic [`CFG_HALF_W-1:0] div_reg;
  logic [4:0] hold_reg;
  logic [3:0] bits_reg;
  logic [7:0] sh_reg;
  logic config_clock_reg;
  logic config_clock_oe_n_reg;
  logic ws_n_reg;
  logic sel_reg;
  logic ready_reg;
  logic [2:0] mode_reg;
  logic mode_oe_n_reg;
  logic wrote_reg;

  wire async_mode = mode_drive && (mode_sel == `CFG_MODE_ASYNC_PER);
  wire div_wrap = (div_reg == `CFG_HALF_W'(`CFG_CONFIG_CLOCK_HALF - 1));
  wire h_fall = (state_reg == H_SHIFT) && div_wrap && config_clock_reg;
  // one full config clock period of ready before the write may end
  wire hold_done = (hold_reg == 5'(2 * `CFG_CONFIG_CLOCK_HALF));
  // a byte held back by the busy wait must not report as taken
  wire take = (state_reg == H_IDLE) && tx_valid && !wrote_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= H_WAIT;
      div_reg <= '0;
      config_clock_reg <= 1'b0;
      bits_reg <= 4'h0;
      sh_reg <= 8'h00;
      hold_reg <= 5'h00;
      ws_n_reg <= 1'b1;
      sel_reg <= 1'b0;
      ready_reg <= 1'b0;
      wrote_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= take;
      case (state_reg)
        H_WAIT:
          if (init_s)
            state_reg <= H_IDLE;
        H_IDLE:
        begin
          div_reg <= '0;
          config_clock_reg <= 1'b0;
          // after a write, wait for busy before the next one
          if (wrote_reg && rdy_fell)
            wrote_reg <= 1'b0;
          if (take && !wrote_reg)
          begin
            sh_reg <= tx_byte;
            bits_reg <= 4'h0;
            hold_reg <= 5'h00;
            state_reg <= async_mode ? H_WRITE : H_SHIFT;
            ws_n_reg <= !async_mode;
            sel_reg <= async_mode;
          end
        end
        H_SHIFT:
        begin
          div_reg <= div_wrap ? '0 : div_reg + `CFG_HALF_W'(1);
          if (div_wrap)
            config_clock_reg <= !config_clock_reg;
          // new bit on our falling edge, device samples rising
          if (h_fall)
          begin
            sh_reg <= {sh_reg[6:0], 1'b0};
            bits_reg <= bits_reg + 4'h1;
            if (bits_reg == 4'h7)
              state_reg <= H_IDLE;
          end
        end
        H_WRITE:
        begin
          hold_reg <= rdy_s ? (hold_done ? hold_reg : hold_reg + 5'h01) :
                      5'h00;
          if (hold_done)
          begin
            ws_n_reg <= 1'b1;
            sel_reg <= 1'b0;
            wrote_reg <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
        default:
          state_reg <= H_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      config_clock_oe_n_reg <= 1'b1;
      mode_reg <= `CFG_MODE_SLAVE_SER;
      mode_oe_n_reg <= 1'b1;
    end
    else
    begin
      config_clock_oe_n_reg <= async_mode;
      mode_reg <= mode_sel;
      mode_oe_n_reg <= !mode_drive;
    end
  end

  assign link.host_mode = mode_reg;
  assign link.host_mode_oe_n = mode_oe_n_reg;
  assign link.host_config_clock = config_clock_reg;
  assign link.host_config_clock_oe_n = config_clock_oe_n_reg;
  assign link.din = sh_reg[7];
  assign link.data = sh_reg;
  // strobe and selects move together, keeping the write window clean
  assign link.write_strobe_n = ws_n_reg;
  assign link.read_strobe = 1'b1;
  assign link.chip_select_low = !sel_reg;
  assign link.chip_select_high = sel_reg;
  assign tx_ready = ready_reg;
  assign link_idle = (state_reg == H_IDLE) && !wrote_reg;
endmodule
`default_nettype wire

// *** src/cfg_link_if.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cfg_consts.svh"
interface cfg_link_if;
  logic [2:0] host_mode;
  logic host_mode_oe_n;
  logic mode_pullup_en;
  logic mode_pin_0;
  logic mode_pin_1;
  logic mode_pin_2;
  logic dev_config_clock;
  logic dev_config_clock_oe_n;
  logic host_config_clock;
  logic host_config_clock_oe_n;
  logic config_clock;
  logic din;
  logic [7:0] data;
  logic write_strobe_n;
  logic read_strobe;
  logic chip_select_low;
  logic chip_select_high;
  logic rdy_busy;
  logic chain_out;
  logic init_out;
  logic init_oe_n;
  logic init_line;
  logic high_during_cfg;
  logic low_during_cfg;
  logic [`CFG_ADDR_W-1:0] prom_address;
  logic read_clock;

  // undriven mode pins float high through the pull-ups
  assign mode_pin_0 = host_mode_oe_n ? mode_pullup_en : host_mode[0];
  assign mode_pin_1 = host_mode_oe_n ? mode_pullup_en : host_mode[1];
  assign mode_pin_2 = host_mode_oe_n ? mode_pullup_en : host_mode[2];
  assign config_clock = !dev_config_clock_oe_n ? dev_config_clock :
                        (!host_config_clock_oe_n ? host_config_clock : 1'b0);
  // wired line with pull-up
  assign init_line = init_oe_n ? 1'b1 : init_out;

  modport dev (
    input mode_pin_0, mode_pin_1, mode_pin_2, config_clock, din, data,
    input write_strobe_n, read_strobe, chip_select_low, chip_select_high,
    output mode_pullup_en, dev_config_clock, dev_config_clock_oe_n, rdy_busy, chain_out,
    output init_out, init_oe_n, high_during_cfg, low_during_cfg,
    output prom_address, read_clock
  );
  modport host (
    output host_mode, host_mode_oe_n, host_config_clock, host_config_clock_oe_n, din, data,
    output write_strobe_n, read_strobe, chip_select_low, chip_select_high,
    input config_clock, rdy_busy, chain_out, init_line
  );
endinterface
`default_nettype wire

// *** src/cfg_pkg.sv ***
package cfg_pkg;
  typedef enum logic [5:0] {
    MODE_SLAVE_SER = 6'h01,
    MODE_MASTER_SER = 6'h02,
    MODE_SYNC_PER = 6'h04,
    MODE_ASYNC_PER = 6'h08,
    MODE_PAR_DOWN = 6'h10,
    MODE_PAR_UP = 6'h20
  } mode_t;

  typedef enum logic [2:0] {
    ST_INIT = 3'h1,
    ST_LOAD = 3'h2,
    ST_DONE = 3'h4
  } dev_state_t;

  typedef enum logic [3:0] {
    H_WAIT = 4'h1,
    H_IDLE = 4'h2,
    H_SHIFT = 4'h4,
    H_WRITE = 4'h8
  } host_state_t;

  function automatic mode_t mode_decode(input logic [2:0] pins);
    case (pins)
      3'h0: mode_decode = MODE_MASTER_SER;
      3'h3: mode_decode = MODE_SYNC_PER;
      3'h5: mode_decode = MODE_ASYNC_PER;
      3'h6: mode_decode = MODE_PAR_DOWN;
      3'h4: mode_decode = MODE_PAR_UP;
      default: mode_decode = MODE_SLAVE_SER;
    endcase
  endfunction
endpackage

// *** src/pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser plus a third stage for edge detection
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] q_prev
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q <= '0;
      q_prev <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
      q_prev <= q;
    end
  end
endmodule
`default_nettype wire
